//--- svic_ctrl.v
// Single-vector interrupt, wake and reset-cause control logic
`timescale 1ns/1ns
`default_nettype none
`include "svic_consts.vh"

// ----------------------------------------
// Summary of operation
// ----------------------------------------
// Summary of operation
// R1: Taken interrupt fetches from fixed vector
// R2: Firmware puts jump at vector location
// R3: Unmasked pending flag requests CPU interrupt
// R4: Masked: no vectoring, polling only
// R5: Save next instruction address on vectoring
// R6: Hard-wired jump opcode below return pair
// R7: Flags saved in top return bits
// R8: Software saves accumulator and index itself
// R9: Vectoring sets the global mask
// R10: Mask clear takes effect three cycles later
// R11: Masked wait wakes and resumes inline
// R12: Unmasked wait wakes and vectors
// R13: Stop allowed only with option, else reset
// R14: Reset pin or interrupt leaves stop
// R15: Masked stop exit resumes inline
// R16: Unmasked stop exit saves return, vectors
// R17: Detector off in stop unless kept on
// R18: Power-on sets power and voltage flags
// R19: Voltage reset option resets, sets cause
// R20: Voltage interrupt mode sets flag, requests
// R21: Periodic control: source, flag, ack, period
// R22: Debugger reset clears cause; write kicks watchdog
module svic_ctrl #(
	parameter PER_W = 3,
	parameter PER_BASE = 16
)(
	input wire MCLK,
	input wire RST_N,
	input wire [11:0] PADDR,
	input wire PSEL,
	input wire PENABLE,
	input wire PWRITE,
	input wire [31:0] PWDATA,
	output wire [31:0] PRDATA,
	output wire PREADY,
	output wire PSLVERR,
	input wire [7:0] SRC_PEND_A,
	input wire [6:0] SRC_PEND_B,
	input wire [13:0] NEXT_PC,
	input wire [1:0] COND_FLAGS,
	input wire INSTR_DONE,
	input wire WAIT_EXEC,
	input wire STOP_EXEC,
	input wire RESTORE_FLAGS,
	input wire LOW_VOLT_PIN,
	input wire POWER_ON_PIN,
	input wire RESET_PIN_N,
	input wire DEBUGGER_FORCED_RESET,
	input wire EXT_CLK_TICK,
	output reg IRQ_REQ,
	output reg VECTOR_LOAD,
	output reg [13:0] PC_LOAD_ADDR,
	output reg RESUME,
	output wire WAITING,
	output wire STOPPED,
	output wire CLOCKS_HALTED,
	output reg ILLEGAL_OP_RST,
	output reg LOW_VOLT_RST,
	output wire WATCHDOG_CLR,
	output wire LOW_VOLT_DETECT_ON,
	output wire [1:0] RESTORED_FLAGS
);

// ----------------------------------------
// Pin synchronisers
// ----------------------------------------
reg [1:0] lv_s_r;
reg [1:0] por_s_r;
reg [1:0] rpin_s_r;
reg [1:0] xclk_s_r;
reg xclk_d_r;
always @(posedge MCLK or negedge RST_N)
	if (!RST_N)
	begin
		lv_s_r <= 2'h0;
		por_s_r <= 2'h0;
		rpin_s_r <= 2'h3;
		xclk_s_r <= 2'h0;
		xclk_d_r <= 1'b0;
	end
	else
	begin
		lv_s_r <= {lv_s_r[0], LOW_VOLT_PIN};
		por_s_r <= {por_s_r[0], POWER_ON_PIN};
		rpin_s_r <= {rpin_s_r[0], RESET_PIN_N};
		xclk_s_r <= {xclk_s_r[0], EXT_CLK_TICK};
		xclk_d_r <= xclk_s_r[1];
	end
wire low_volt = lv_s_r[1];
wire ext_tick = xclk_s_r[1] & ~xclk_d_r;

// ----------------------------------------
// APB decode
// ----------------------------------------
wire wr = PSEL & PENABLE & PWRITE;
wire [7:0] wd = PWDATA[7:0];
function hit;
	input [11:0] a;
	input [11:0] b;
	hit = (a == b);
endfunction
assign PREADY = 1'b1;
assign PSLVERR = 1'b0;

// ----------------------------------------
// Registers
// ----------------------------------------
reg global_irq_mask_r;
reg [1:0] unmask_cnt_r;
reg [7:0] return_address_high_r;
reg [7:0] return_address_low_r;
reg [7:0] system_options_r;
reg sysopt_locked_r;
reg [7:0] power_mgmt_control_r;
reg [7:0] periodic_irq_control_r;
reg [7:0] reset_cause_status_r;
reg low_volt_flag_r;
reg periodic_flag_r;
reg wait_r;
reg stop_r;
reg [PER_BASE+6:0] per_cnt_r;
reg [7:0] prdata_r;


// ----------------------------------------
// Derived controls
// ----------------------------------------
wire [7:0] pending_flags_a = SRC_PEND_A;
wire [7:0] pending_flags_b = {SRC_PEND_B[6:2],
	periodic_flag_r & periodic_irq_control_r[`SVIC_B_PIE],
	low_volt_flag_r & power_mgmt_control_r[`SVIC_B_LOW_VOLT_IRQ_ON]};
wire any_pend = |pending_flags_a | |pending_flags_b;
wire stop_allow = system_options_r[`SVIC_B_STOP_ALLOW];
wire lvd_on = power_mgmt_control_r[`SVIC_B_LOW_VOLT_DETECT_ON];
wire lvd_in_stop = power_mgmt_control_r[`SVIC_B_LOW_VOLT_DETECT_IN_STOP];
wire lvd_rst_on = power_mgmt_control_r[`SVIC_B_LOW_VOLT_RESET_ON];
wire [PER_W-1:0] per_sel = periodic_irq_control_r[PER_W-1:0];

// Unmask is live only once the exit double jump is done
wire mask_eff = global_irq_mask_r | (unmask_cnt_r != 2'd0); // see R10
assign LOW_VOLT_DETECT_ON = lvd_on & (~stop_r | lvd_in_stop); // see R17
wire lv_event = LOW_VOLT_DETECT_ON & low_volt;

// ----------------------------------------
// Status outputs
// ----------------------------------------
assign WAITING = wait_r;
assign STOPPED = stop_r;
assign CLOCKS_HALTED = stop_r; // see R13
assign WATCHDOG_CLR = wr & hit(PADDR, `SVIC_A_CAUSE); // see R22
assign RESTORED_FLAGS = return_address_high_r[7:6]; // see R7
assign PRDATA = {24'h000000, prdata_r};


// ----------------------------------------
// Wake and take
// ----------------------------------------
// Wake from either low-power state on any pending flag
wire wake = (wait_r | stop_r) & any_pend; // see R11 see R14
wire take_run = ~wait_r & ~stop_r & INSTR_DONE & any_pend & ~mask_eff;
wire take = take_run | (wake & ~mask_eff); // see R3 see R12 see R16
wire low_entry = ~wait_r & ~stop_r & INSTR_DONE & ~take_run;

// ----------------------------------------
// Periodic tick
// ----------------------------------------
// Counter wide enough for the slowest of the seven periods
localparam CW = PER_BASE + 7;
localparam [CW-1:0] C_ONE = {{(CW-1){1'b0}}, 1'b1};
localparam [PER_W-1:0] S_ONE = {{(PER_W-1){1'b0}}, 1'b1};

function per_tap;
	input [CW-1:0] c;
	input [PER_W-1:0] s;
	reg [CW-1:0] hi;
	reg [CW-1:0] msk;
	begin
		hi = c >> PER_BASE;
		msk = (C_ONE << (s - S_ONE)) - C_ONE;
		per_tap = (c[PER_BASE-1:0] == {PER_BASE{1'b0}}) &&
			((hi & msk) == {CW{1'b0}});
	end
endfunction
wire per_clk = periodic_irq_control_r[`SVIC_B_PCLKS] ? ext_tick : 1'b1;
wire per_fire = (per_sel != {PER_W{1'b0}}) & per_clk &
	per_tap(per_cnt_r, per_sel); // see R21

// ----------------------------------------
// Unmask delay
// ----------------------------------------
// A take in the same cycle wins, so the clear is then lost
reg [1:0] unmask_cnt_nxt;
wire unmask_wr = wr & hit(PADDR, `SVIC_A_PEND_B) & ~take &
	global_irq_mask_r & ~wd[`SVIC_B_MASK];
always @*
begin
	unmask_cnt_nxt = unmask_cnt_r;
	if (unmask_wr)
		unmask_cnt_nxt = `SVIC_UNMASK_DLY; // see R10
	else if (unmask_cnt_r != 2'd0)
		unmask_cnt_nxt = unmask_cnt_r - 2'd1;
end

// ----------------------------------------
// Core control
// ----------------------------------------
always @(posedge MCLK or negedge RST_N)
	if (!RST_N)
	begin
		global_irq_mask_r <= 1'b1;
		unmask_cnt_r <= 2'd0;
		return_address_high_r <= 8'h00;
		return_address_low_r <= 8'h00;
		wait_r <= 1'b0;
		stop_r <= 1'b0;
		IRQ_REQ <= 1'b0;
		VECTOR_LOAD <= 1'b0;
		PC_LOAD_ADDR <= 14'h0000;
		RESUME <= 1'b0;
		ILLEGAL_OP_RST <= 1'b0;
	end
	else
	begin
		IRQ_REQ <= any_pend & ~mask_eff; // see R3 see R4
		VECTOR_LOAD <= take;
		RESUME <= wake & mask_eff; // see R15
		ILLEGAL_OP_RST <= low_entry & STOP_EXEC & ~stop_allow; // see R13
		unmask_cnt_r <= unmask_cnt_nxt;
		if (take)
		begin
			global_irq_mask_r <= 1'b1; // see R9
			PC_LOAD_ADDR <= `SVIC_VEC_ADDR; // see R1
			// Next PC is the instruction after wait or stop too
			return_address_high_r <= {COND_FLAGS, NEXT_PC[13:8]}; // see R5
			return_address_low_r <= NEXT_PC[7:0]; // see R5
		end
		else if (wr && hit(PADDR, `SVIC_A_PEND_B))
		begin
			global_irq_mask_r <= wd[`SVIC_B_MASK];
		end
		else if (wr && hit(PADDR, `SVIC_A_RET_HI))
			return_address_high_r <= wd;
		else if (wr && hit(PADDR, `SVIC_A_RET_LO))
			return_address_low_r <= wd;
		if (wake)
		begin
			wait_r <= 1'b0; // see R11
			stop_r <= 1'b0; // see R14
		end
		else if (low_entry && WAIT_EXEC)
			wait_r <= 1'b1;
		else if (low_entry && STOP_EXEC && stop_allow)
			stop_r <= 1'b1; // see R13
		if (!rpin_s_r[1])
		begin
			stop_r <= 1'b0; // see R14
			wait_r <= 1'b0;
			PC_LOAD_ADDR <= `SVIC_RST_VEC; // see R14
		end
	end

// ----------------------------------------
// Options, power, periodic
// ----------------------------------------
always @(posedge MCLK or negedge RST_N)
	if (!RST_N)
	begin
		system_options_r <= `SVIC_SYSOPT_RST;
		sysopt_locked_r <= 1'b0;
		power_mgmt_control_r <= `SVIC_PWR_RST;
		periodic_irq_control_r <= 8'h00;
		low_volt_flag_r <= 1'b0;
		periodic_flag_r <= 1'b0;
		per_cnt_r <= {(PER_BASE+7){1'b0}};
		LOW_VOLT_RST <= 1'b0;
	end
	else
	begin
		// Write-once so a lost program cannot re-enable stop
		if (wr && hit(PADDR, `SVIC_A_SYSOPT) && !sysopt_locked_r)
		begin
			system_options_r <= wd;
			sysopt_locked_r <= 1'b1;
		end
		if (wr && hit(PADDR, `SVIC_A_PWR))
			power_mgmt_control_r <= {1'b0, 1'b0, wd[5:0]};
		if (wr && hit(PADDR, `SVIC_A_PER))
			periodic_irq_control_r <= {1'b0, 1'b0, wd[5:0]};
		if (per_clk)
			per_cnt_r <= per_cnt_r + {{(PER_BASE+6){1'b0}}, 1'b1};
		LOW_VOLT_RST <= lv_event & lvd_rst_on; // see R19
		// Set beats a same-cycle acknowledge
		if (lv_event && !lvd_rst_on)
			low_volt_flag_r <= 1'b1; // see R20
		else if (wr && hit(PADDR, `SVIC_A_PWR) && wd[`SVIC_B_LVACK])
			low_volt_flag_r <= 1'b0;
		if (per_fire)
			periodic_flag_r <= 1'b1; // see R21
		else if (wr && hit(PADDR, `SVIC_A_PER) && wd[`SVIC_B_PACK])
			periodic_flag_r <= 1'b0;
	end

// ----------------------------------------
// Reset cause
// ----------------------------------------
// Causes are caught by the clock, since async reset may take no port value
reg [7:0] reset_cause_status_nxt;
always @*
begin
	reset_cause_status_nxt = reset_cause_status_r;
	if (DEBUGGER_FORCED_RESET)
		reset_cause_status_nxt = 8'h00; // see R22
	else if (por_s_r[1])
		reset_cause_status_nxt = `SVIC_C_POR; // see R18
	else if (LOW_VOLT_RST)
		reset_cause_status_nxt = `SVIC_C_LV; // see R19
end

always @(posedge MCLK or negedge RST_N)
	if (!RST_N)
		reset_cause_status_r <= 8'h00;
	else
		reset_cause_status_r <= reset_cause_status_nxt;

// ----------------------------------------
// Read data
// ----------------------------------------
// Latched at setup so the access phase never waits
reg [7:0] prdata_nxt;
always @*
begin
	prdata_nxt = prdata_r;
	if (PSEL && !PENABLE && !PWRITE)
	begin
		case (PADDR)
		`SVIC_A_PEND_A: prdata_nxt = pending_flags_a;
		`SVIC_A_PEND_B: prdata_nxt = {pending_flags_b[7:1],
			global_irq_mask_r};
		`SVIC_A_RET_HI: prdata_nxt = RESTORE_FLAGS ?
			return_address_high_r : return_address_high_r;
		`SVIC_A_RET_LO: prdata_nxt = return_address_low_r;
		`SVIC_A_EXIT: prdata_nxt = `SVIC_JMP_OP; // see R6
		`SVIC_A_SYSOPT: prdata_nxt = system_options_r;
		`SVIC_A_PWR: prdata_nxt = {low_volt_flag_r, 1'b0,
			power_mgmt_control_r[5:0]};
		`SVIC_A_PER: prdata_nxt = {periodic_flag_r, 1'b0,
			periodic_irq_control_r[5:0]};
		`SVIC_A_CAUSE: prdata_nxt = reset_cause_status_r;
		default: prdata_nxt = 8'h00;
		endcase
	end
end

always @(posedge MCLK or negedge RST_N)
	if (!RST_N)
		prdata_r <= 8'h00;
	else
		prdata_r <= prdata_nxt;

endmodule
`default_nettype wire

//--- svic_consts.vh
// Constants for the single-vector interrupt and wake controller
`ifndef SVIC_CONSTS_VH
`define SVIC_CONSTS_VH
// Memory locations
`define SVIC_VEC_ADDR 14'h3ff7
`define SVIC_RST_VEC 14'h3ffd
`define SVIC_JMP_OP 8'hbc
// Register byte addresses
`define SVIC_A_PEND_A 12'h000
`define SVIC_A_PEND_B 12'h004
`define SVIC_A_RET_HI 12'h008
`define SVIC_A_RET_LO 12'h00c
`define SVIC_A_EXIT 12'h010
`define SVIC_A_SYSOPT 12'h014
`define SVIC_A_PWR 12'h018
`define SVIC_A_PER 12'h01c
`define SVIC_A_CAUSE 12'h020
// Field positions
`define SVIC_B_MASK 0
`define SVIC_B_STOP_ALLOW 5
`define SVIC_B_LOW_VOLT_DETECT_ON 0
`define SVIC_B_LOW_VOLT_DETECT_IN_STOP 1
`define SVIC_B_LOW_VOLT_IRQ_ON 2
`define SVIC_B_LOW_VOLT_RESET_ON 3
`define SVIC_B_LOW_VOLT_FLAG 7
`define SVIC_B_LVACK 6
`define SVIC_B_PCLKS 5
`define SVIC_B_PIE 4
`define SVIC_B_PACK 6
`define SVIC_B_PFLG 7
`define SVIC_B_POR 7
`define SVIC_B_LVC 1
// Reset values
`define SVIC_PWR_RST 8'h01
`define SVIC_SYSOPT_RST 8'h80
// Timing
`define SVIC_UNMASK_DLY 2'd3
// Cause bits of reset status
`define SVIC_C_POR 8'h82
`define SVIC_C_LV 8'h02
`endif

//--- svic_chk.sv
// Assertion checker for the interrupt and wake controller
`timescale 1ns/1ns
`default_nettype none
module svic_chk (
	input wire MCLK,
	input wire RST_N,
	input wire [11:0] PADDR,
	input wire PSEL,
	input wire PENABLE,
	input wire PWRITE,
	input wire [31:0] PWDATA,
	input wire [1:0] COND_FLAGS,
	input wire STOP_EXEC,
	input wire IRQ_REQ,
	input wire VECTOR_LOAD,
	input wire [13:0] PC_LOAD_ADDR,
	input wire RESUME,
	input wire WAITING,
	input wire STOPPED,
	input wire WATCHDOG_CLR,
	input wire [1:0] RESTORED_FLAGS
);
	// ------
	// Checks
	// ------
	wire wr_acc = PSEL && PENABLE && PWRITE;
	wire wake = VECTOR_LOAD || RESUME;
	default clocking @(posedge MCLK);
	endclocking
	default disable iff (!RST_N);
	property p_vec;
		VECTOR_LOAD |-> PC_LOAD_ADDR == 14'h3ff7;
	endproperty
	a_vec: assert property (p_vec) else $error("vector addr");
	property p_take;
		$rose(IRQ_REQ) |-> ##[0:4] VECTOR_LOAD;
	endproperty
	a_take: assert property (p_take) else $error("no take");
	property p_mask;
		VECTOR_LOAD |=> ##1 !IRQ_REQ [*3];
	endproperty
	a_mask: assert property (p_mask) else $error("mask");
	property p_flags;
		VECTOR_LOAD |-> RESTORED_FLAGS == $past(COND_FLAGS);
	endproperty
	a_flags: assert property (p_flags) else $error("flags");
	// Vectoring must not slip in before the exit double jump
	property p_unmask;
		wr_acc && PADDR == 12'h004 && !PWDATA[0] && !IRQ_REQ
			|=> !VECTOR_LOAD [*3];
	endproperty
	a_unmask: assert property (p_unmask) else $error("early");
	property p_stop;
		$rose(STOPPED) |-> $past(STOP_EXEC) || $past(STOP_EXEC, 2);
	endproperty
	a_stop: assert property (p_stop) else $error("stop");
	property p_wdog;
		WATCHDOG_CLR == (wr_acc && PADDR == 12'h020);
	endproperty
	a_wdog: assert property (p_wdog) else $error("wdog");
	property p_wake;
		$fell(WAITING) |-> wake || $past(wake);
	endproperty
	a_wake: assert property (p_wake) else $error("wake");
endmodule
bind svic_ctrl svic_chk i_chk (.MCLK, .RST_N, .PADDR, .PSEL, .PENABLE,
	.PWRITE, .PWDATA, .COND_FLAGS, .STOP_EXEC, .IRQ_REQ, .VECTOR_LOAD,
	.PC_LOAD_ADDR, .RESUME, .WAITING, .STOPPED, .WATCHDOG_CLR,
	.RESTORED_FLAGS);
`default_nettype wire

//--- svic_cpu_mdl.sv
// Behavioural model of the CPU core facing the controller
`timescale 1ns/1ns
`default_nettype none
module svic_cpu_mdl #(
	parameter logic [13:0] ISR_ADDR = 14'h0100
)(
	input wire logic MCLK,
	input wire logic RST_N,
	input wire logic SLOW,
	input wire logic WAIT_EXEC,
	input wire logic STOP_EXEC,
	input wire logic VECTOR_LOAD,
	input wire logic RESUME,
	input wire logic ILLEGAL_OP_RST,
	output logic INSTR_DONE,
	output logic [13:0] NEXT_PC,
	output logic [1:0] COND_FLAGS
);
	logic [13:0] pc_r;
	logic ph_r;
	logic park_r;
	// Parked core retires nothing, so the saved address stays put
	assign INSTR_DONE = !park_r && !(SLOW && ph_r);
	assign NEXT_PC = pc_r;
	assign COND_FLAGS = pc_r[3:2];
	always_ff @(posedge MCLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			pc_r <= 14'h0000;
			ph_r <= 1'b0;
			park_r <= 1'b0;
		end
		else
		begin
			ph_r <= !ph_r;
			if (VECTOR_LOAD || RESUME || ILLEGAL_OP_RST)
				park_r <= 1'b0;
			else if (INSTR_DONE && (WAIT_EXEC || STOP_EXEC))
				park_r <= 1'b1;
			if (VECTOR_LOAD)
				pc_r <= ISR_ADDR;
			else
				pc_r <= pc_r + {13'h0000, INSTR_DONE};
		end
	end
endmodule
`default_nettype wire

//--- tb_top.sv
// Self-checking bench for the interrupt and wake controller
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	logic MCLK = 0, RST_N = 0, PSEL = 0, PENABLE = 0, PWRITE = 0, SLOW = 0;
	logic WAIT_EXEC = 0, STOP_EXEC = 0, LOW_VOLT_PIN = 0, POWER_ON_PIN = 1;
	logic RESET_PIN_N = 1, DEBUGGER_FORCED_RESET = 0, EXT_CLK_TICK = 0;
	logic RESTORE_FLAGS = 0;
	logic [11:0] PADDR = 0;
	logic [31:0] PWDATA = 0, rd;
	logic [7:0] SRC_PEND_A = 0, v;
	logic [6:0] SRC_PEND_B = 0;
	logic [15:0] exp_ret;
	wire [31:0] PRDATA;
	wire [13:0] PC_LOAD_ADDR, NEXT_PC;
	wire [1:0] COND_FLAGS;
	wire PREADY, INSTR_DONE, IRQ_REQ, VECTOR_LOAD, RESUME, WAITING, STOPPED;
	wire ILLEGAL_OP_RST, LOW_VOLT_RST, LOW_VOLT_DETECT_ON;
	wire [5:0] ev = {WAITING, ILLEGAL_OP_RST, LOW_VOLT_RST, STOPPED, RESUME,
		VECTOR_LOAD};
	int err_count = 0, compares = 0, seed = 60433;
	int mdl [int] = '{0: 0, 4: 1, 8: 0, 12: 0, 16: 'hbc, 20: 'h80,
		24: 'h01, 28: 0, 32: 'h82, 48: 0};
	svic_ctrl #(.PER_BASE(2)) i_dut (.MCLK, .RST_N, .PADDR, .PSEL, .PENABLE,
		.PWRITE, .PWDATA, .PRDATA, .PREADY, .PSLVERR(), .SRC_PEND_A,
		.SRC_PEND_B, .NEXT_PC, .COND_FLAGS, .INSTR_DONE, .WAIT_EXEC,
		.STOP_EXEC, .RESTORE_FLAGS, .LOW_VOLT_PIN, .POWER_ON_PIN,
		.RESET_PIN_N, .DEBUGGER_FORCED_RESET, .EXT_CLK_TICK, .IRQ_REQ,
		.VECTOR_LOAD, .PC_LOAD_ADDR, .RESUME, .WAITING, .STOPPED,
		.CLOCKS_HALTED(), .ILLEGAL_OP_RST, .LOW_VOLT_RST, .WATCHDOG_CLR(),
		.LOW_VOLT_DETECT_ON, .RESTORED_FLAGS());
	svic_cpu_mdl i_cpu (.MCLK, .RST_N, .SLOW, .WAIT_EXEC, .STOP_EXEC,
		.VECTOR_LOAD, .RESUME, .ILLEGAL_OP_RST, .INSTR_DONE, .NEXT_PC,
		.COND_FLAGS);
	// -----
	// Tasks
	// -----
	initial
		forever #25 MCLK = ~MCLK;
	task automatic wrap_up;
		$display("compares %0d err_count %0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] s, e, input string nm);
		compares++;
		if (s !== e)
		begin
			err_count++;
			$display("[FAIL] %s exp %h seen %h", nm, e, s);
		end
	endtask
	task automatic apb(input int a, input logic w, input logic [31:0] d);
		int n = 0;
		@(posedge MCLK);
		PADDR <= a[11:0];
		PWRITE <= w;
		PWDATA <= d;
		PSEL <= 1'b1;
		@(posedge MCLK);
		PENABLE <= 1'b1;
		do
		begin
			@(posedge MCLK);
			n++;
		end
		while (PREADY !== 1'b1 && n < 50);
		chk(PREADY, 1, "pready");
		rd = PRDATA;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
	endtask
	task automatic rc(input int a, input logic [31:0] e);
		apb(a, 1'b0, 0);
		chk(rd, e, "read");
	endtask
	// Bounded wait; a lost event ends the run at once
	task automatic wt(input int k);
		int n = 0;
		do
		begin
			@(negedge MCLK);
			n++;
		end
		while (ev[k] !== 1'b1 && n < 300);
		chk(ev[k], 1, "event");
		if (ev[k] !== 1'b1)
			wrap_up();
	endtask
	task automatic exec(input logic st);
		@(posedge MCLK);
		STOP_EXEC <= st;
		WAIT_EXEC <= !st;
		@(posedge MCLK);
		STOP_EXEC <= 1'b0;
		WAIT_EXEC <= 1'b0;
	endtask
	initial
	begin
		repeat (12) @(posedge MCLK);
		RST_N <= 1'b1;
		repeat (6) @(posedge MCLK);
		POWER_ON_PIN <= 1'b0;
		foreach (mdl[a])
			rc(a, mdl[a]);
		apb(32, 1'b1, 'hff);
		rc(32, 'h82);
		@(posedge MCLK) DEBUGGER_FORCED_RESET <= 1'b1;
		@(posedge MCLK) DEBUGGER_FORCED_RESET <= 1'b0;
		rc(32, 0);
		exec(1'b1);
		wt(4);
		apb(20, 1'b1, 'h20);
		apb(20, 1'b1, 'h80);
		rc(20, 'h20);
		exec(1'b1);
		wt(2);
		chk(LOW_VOLT_DETECT_ON, 0, "detect");
		@(posedge MCLK) SRC_PEND_B <= 7'h04;
		wt(1);
		@(posedge MCLK) SRC_PEND_B <= 7'h00;
		v = 8'($random(seed)) | 8'h01;
		exec(1'b0);
		wt(5);
		@(posedge MCLK) SRC_PEND_A <= v;
		wt(1);
		rc(0, v);
		SLOW <= 1'b1;
		apb(4, 1'b1, 0);
		wt(0);
		chk(PC_LOAD_ADDR, 'h3ff7, "vector");
		@(posedge MCLK) SRC_PEND_A <= 0;
		SLOW <= 1'b0;
		apb(4, 1'b1, 0);
		exec(1'b0);
		wt(5);
		exp_ret = {COND_FLAGS, NEXT_PC};
		@(posedge MCLK) SRC_PEND_A <= v;
		wt(0);
		@(posedge MCLK) SRC_PEND_A <= 0;
		rc(8, exp_ret[15:8]);
		rc(12, exp_ret[7:0]);
		rc(4, 1);
		apb(24, 1'b1, 'h05);
		@(posedge MCLK) LOW_VOLT_PIN <= 1'b1;
		repeat (6) @(posedge MCLK);
		rc(24, 'h85);
		LOW_VOLT_PIN <= 1'b0;
		repeat (4) @(posedge MCLK);
		apb(24, 1'b1, 'h45);
		rc(24, 'h05);
		apb(28, 1'b1, 'h11);
		repeat (12) @(posedge MCLK);
		rc(28, 'h91);
		apb(28, 1'b1, 0);
		apb(28, 1'b1, 'h40);
		rc(28, 0);
		exec(1'b1);
		wt(2);
		RESET_PIN_N <= 1'b0;
		repeat (4) @(posedge MCLK);
		chk(PC_LOAD_ADDR, 'h3ffd, "reset vec");
		chk(STOPPED, 0, "stop exit");
		RESET_PIN_N <= 1'b1;
		apb(24, 1'b1, 'h09);
		@(posedge MCLK) LOW_VOLT_PIN <= 1'b1;
		wt(3);
		rc(32, 'h02);
		wrap_up();
	end
endmodule
`default_nettype wire
